// [core/slt_buf2.sv]
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and a reset already synchronised to it.
*/
`timescale 1ns/1ns
`default_nettype none

module slt_buf2 #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output var  logic         in_ready,
  output var  logic [W-1:0] out_data,
  output var  logic         out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_q [0:1];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         push;
  logic         pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rp_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop & ~push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // Ready is registered so the top sees it straight from a flop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q    <= 2'h0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= cnt_d != 2'h2;
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

// [core/slt_cfg.svh]
/*
 Register offsets, field positions, reset values and serial-port frame
 counts of the serial link transport configuration bank.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef SLT_CFG_SVH
`define SLT_CFG_SVH

`define SLT_A_FORMAT   12'h110
`define SLT_A_FEATURE  12'h111
`define SLT_A_INTERP   12'h112
`define SLT_A_GAIN     12'h113
`define SLT_A_DCOFS    12'h114
`define SLT_A_PHASE    12'h115
`define SLT_A_GDELAY   12'h116
`define SLT_A_STATUS   12'h117
`define SLT_A_IFPWR    12'h200
`define SLT_A_LANEPD   12'h201
`define SLT_A_LINKCTL  12'h300
`define SLT_A_DID      12'h450
`define SLT_A_BID      12'h451
`define SLT_A_LID      12'h452
`define SLT_A_LANES    12'h453
`define SLT_A_OCTETS   12'h454
`define SLT_A_FRAMES   12'h455
`define SLT_A_CONVS    12'h456
`define SLT_A_RESOL    12'h457
`define SLT_A_NPBITS   12'h458
`define SLT_A_VERSION  12'h459
`define SLT_A_DENSITY  12'h45a
`define SLT_A_CSUM     12'h45d
`define SLT_A_DESKEW   12'h46c
`define SLT_A_FSET     12'h476
`define SLT_A_LANEEN   12'h47d

`define SLT_B_FMT      7
`define SLT_B_MOD      0
`define SLT_B_ISINC    1
`define SLT_B_PHASE    2
`define SLT_B_DCOFS    3
`define SLT_B_PROT     4
`define SLT_B_DUAL     3
`define SLT_B_LSEL     2
`define SLT_VER_LSB    5
`define SLT_VER_REV_B  3'h1

`define SLT_R_FEATURE  8'h02
`define SLT_R_GAIN     8'h40
`define SLT_R_IFPWR    8'hff
`define SLT_R_ZERO     8'h00
`define SLT_GAIN_SHIFT 6
`define SLT_PHASE_SHIFT 7
`define SLT_ISINC_SHIFT 4

`define SLT_SPI_INSTR  5'd16
`define SLT_SPI_FRAME  5'd24
`define SLT_BANK_REGS  13

`endif

// [core/slt_datapath.sv]
/*
 Sample datapath: format, inverse sinc, gain, phase, offset, modulation,
 protection, group delay and sample-hold interpolation.
 Assumes a configuration struct held steady by the register bank.
*/
`timescale 1ns/1ns
`default_nettype none
`include "slt_cfg.svh"

module slt_datapath (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire slt_pkg::slt_dp_cfg_t cfg,
  input  wire logic [15:0]         in_data,
  input  wire logic                in_valid,
  output var  logic                in_ready,
  output var  logic [15:0]         out_data,
  output var  logic                out_valid,
  input  wire logic                out_ready
);
  import slt_pkg::*;

  slt_word_t          hist_q [0:1];
  slt_word_t          ydel_q [0:2];
  slt_word_t          xs;
  slt_word_t          y;
  logic        [2:0]  rep_q;
  logic               flip_q;
  logic               pop;
  logic signed [19:0] s1;
  logic signed [19:0] s3;
  logic signed [19:0] s4;
  logic signed [19:0] s5;
  logic signed [19:0] dif;
  logic signed [28:0] g;
  logic signed [23:0] p;

  assign in_ready = ~out_valid | (out_ready & rep_q == 3'h0);
  assign pop      = in_valid & in_ready;

  always_comb begin
    xs  = cfg.unsigned_fmt ? {~in_data[15], in_data[14:0]}
                           : in_data;
    dif = 20'(2 * 20'(xs)) - 20'(hist_q[0]) - 20'(hist_q[1]);
    s1  = 20'(xs);
    if (cfg.isinc_en) begin
      s1 = 20'(xs) + (dif >>> `SLT_ISINC_SHIFT);
    end
    g  = s1 * $signed({1'b0, cfg.gain});
    p  = hist_q[0] * $signed(cfg.phase);
    s3 = 20'(g >>> `SLT_GAIN_SHIFT);
    if (cfg.phase_en) begin
      s3 = s3 + 20'(p >>> `SLT_PHASE_SHIFT);
    end
    s4 = s3;
    if (cfg.dc_en) begin
      s4 = s3 + {{8{cfg.dc_ofs[7]}}, cfg.dc_ofs, 4'h0};
    end
    s5 = (cfg.mod_en & flip_q) ? -s4 : s4;
    if (s5 > 20'sh07fff) begin
      y = 16'sh7fff;
    end else if (s5 < -20'sh08000) begin
      y = -16'sh8000;
    end else begin
      y = s5[15:0];
    end
    if (cfg.prot_en & ~cfg.link_up) begin
      y = 16'sh0000;
    end
  end

  // Each accepted sample is held for the interpolation ratio in beats.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= 16'h0000;
      rep_q     <= 3'h0;
      flip_q    <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        hist_q[i] <= 16'sh0000;
      end
      for (int i = 0; i < 3; i++) begin
        ydel_q[i] <= 16'sh0000;
      end
    end else if (pop) begin
      out_valid <= 1'b1;
      rep_q     <= 3'((4'h1 << cfg.interp) - 4'h1);
      flip_q    <= ~flip_q;
      hist_q[0] <= xs;
      hist_q[1] <= hist_q[0];
      ydel_q[0] <= y;
      ydel_q[1] <= ydel_q[0];
      ydel_q[2] <= ydel_q[1];
      out_data  <= (cfg.gdelay == 2'h0) ? y
                                        : ydel_q[cfg.gdelay - 2'h1];
    end else if (out_valid & out_ready) begin
      if (rep_q == 3'h0) begin
        out_valid <= 1'b0;
      end else begin
        rep_q <= rep_q - 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

// [core/slt_pkg.sv]
/*
 Types shared by the transport configuration bank and its datapath.
 Assumes slt_cfg.svh is on the include path.
*/
`default_nettype none
`include "slt_cfg.svh"

package slt_pkg;

  typedef logic signed [15:0] slt_word_t;

  typedef struct packed {
    logic       unsigned_fmt;
    logic       mod_en;
    logic       isinc_en;
    logic       phase_en;
    logic       dc_en;
    logic       prot_en;
    logic       link_up;
    logic [1:0] interp;
    logic [1:0] gdelay;
    logic [7:0] gain;
    logic [7:0] dc_ofs;
    logic [7:0] phase;
  } slt_dp_cfg_t;

  typedef enum logic [1:0] {
    SLT_IDLE  = 2'b00,
    SLT_INSTR = 2'b01,
    SLT_DATA  = 2'b10
  } slt_spi_state_t;

endpackage

`default_nettype wire

// [core/slt_top.sv]
/*
 Serial link transport configuration bank with its serial port,
 identifier check and sample datapath.
 Assumes all pins synchronous to CLOCK and a serial clock far slower.
*/
`timescale 1ns/1ns
`default_nettype none
`include "slt_cfg.svh"

module slt_top (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        SPI_CS_N,
  input  wire logic        SPI_SCLK,
  input  wire logic        SPI_SDI,
  output var  logic        SPI_SDO,
  output var  logic        SPI_SDO_OE_N,
  input  wire logic [15:0] SAMPLE_IN,
  input  wire logic        SAMPLE_IN_VALID,
  output var  logic        SAMPLE_IN_READY,
  output var  logic [15:0] DAC_DATA,
  output var  logic        DAC_VALID,
  input  wire logic        DAC_READY,
  input  wire logic        RX_ID_VALID,
  input  wire logic        RX_ID_LINK,
  input  wire logic [7:0]  RX_DID,
  input  wire logic [7:0]  RX_BID,
  input  wire logic [7:0]  RX_LID,
  output var  logic        ID_MISMATCH,
  output var  logic        LINK_POWER_UP,
  output var  logic [7:0]  LANE_ACTIVE,
  output var  logic [7:0]  DESKEW_LANES,
  output var  logic [4:0]  LANE_COUNT_M1,
  output var  logic        PROTOCOL_REV_B,
  output var  logic        TWO_LINK_ENABLE
);
  import slt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial port: 16-bit instruction (read flag, address), 8 data bits.

  slt_spi_state_t state_q;
  logic           sclk_q;
  logic           rise;
  logic           fall;
  logic [4:0]     bit_q;
  logic [22:0]    shin_q;
  logic           rd_q;
  logic [11:0]    addr_q;
  logic           load_q;
  logic [7:0]     rdsh_q;
  logic           wr_q;
  logic [7:0]     wdata_q;
  logic [7:0]     rdata;

  assign rise = SPI_SCLK & ~sclk_q;
  assign fall = ~SPI_SCLK & sclk_q;

  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q      <= SLT_IDLE;
      sclk_q       <= 1'b0;
      bit_q        <= 5'h0;
      shin_q       <= 23'h0;
      rd_q         <= 1'b0;
      addr_q       <= 12'h000;
      load_q       <= 1'b0;
      rdsh_q       <= 8'h00;
      wr_q         <= 1'b0;
      wdata_q      <= 8'h00;
      SPI_SDO      <= 1'b0;
      SPI_SDO_OE_N <= 1'b1;
    end else begin
      sclk_q <= SPI_SCLK;
      wr_q   <= 1'b0;
      load_q <= 1'b0;
      if (load_q) begin
        rdsh_q <= rdata;
      end
      if (SPI_CS_N) begin
        state_q      <= SLT_IDLE;
        bit_q        <= 5'h0;
        SPI_SDO_OE_N <= 1'b1;
      end else begin
        case (state_q)
          SLT_IDLE: begin
            state_q <= SLT_INSTR;
          end
          SLT_INSTR: begin
            if (rise) begin
              shin_q <= {shin_q[21:0], SPI_SDI};
              bit_q  <= bit_q + 5'h1;
              if (bit_q == `SLT_SPI_INSTR - 5'h1) begin
                rd_q    <= shin_q[14];
                addr_q  <= {shin_q[10:0], SPI_SDI};
                load_q  <= shin_q[14];
                state_q <= SLT_DATA;
              end
            end
          end
          SLT_DATA: begin
            if (rd_q) begin
              SPI_SDO_OE_N <= 1'b0;
            end
            if (fall & rd_q) begin
              SPI_SDO <= rdsh_q[7];
              rdsh_q  <= {rdsh_q[6:0], 1'b0};
            end
            if (rise) begin
              shin_q <= {shin_q[21:0], SPI_SDI};
              bit_q  <= bit_q + 5'h1;
              if (bit_q == `SLT_SPI_FRAME - 5'h1) begin
                wr_q    <= ~rd_q;
                wdata_q <= {shin_q[6:0], SPI_SDI};
                state_q <= SLT_IDLE;
              end
            end
          end
          default: begin
            state_q <= SLT_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared datapath and link-common registers.

  logic [7:0] format_q;
  logic [7:0] feature_q;
  logic [7:0] interp_q;
  logic [7:0] gain_q;
  logic [7:0] dcofs_q;
  logic [7:0] phase_q;
  logic [7:0] gdelay_q;
  logic [7:0] ifpwr_q;
  logic [7:0] lanepd_q;
  logic [7:0] linkctl_q;
  logic       lsel;

  // Link control is kept single so the select bit cannot hide itself.
  assign lsel = linkctl_q[`SLT_B_LSEL];

  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      format_q  <= `SLT_R_ZERO;
      feature_q <= `SLT_R_FEATURE;
      interp_q  <= `SLT_R_ZERO;
      gain_q    <= `SLT_R_GAIN;
      dcofs_q   <= `SLT_R_ZERO;
      phase_q   <= `SLT_R_ZERO;
      gdelay_q  <= `SLT_R_ZERO;
      ifpwr_q   <= `SLT_R_IFPWR;
      lanepd_q  <= `SLT_R_ZERO;
      linkctl_q <= `SLT_R_ZERO;
    end else if (wr_q) begin
      case (addr_q)
        `SLT_A_FORMAT:  format_q  <= wdata_q;
        `SLT_A_FEATURE: feature_q <= wdata_q;
        `SLT_A_INTERP:  interp_q  <= wdata_q;
        `SLT_A_GAIN:    gain_q    <= wdata_q;
        `SLT_A_DCOFS:   dcofs_q   <= wdata_q;
        `SLT_A_PHASE:   phase_q   <= wdata_q;
        `SLT_A_GDELAY:  gdelay_q  <= wdata_q;
        `SLT_A_IFPWR:   ifpwr_q   <= wdata_q;
        `SLT_A_LANEPD:  lanepd_q  <= wdata_q;
        `SLT_A_LINKCTL: linkctl_q <= wdata_q;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-link banked registers, one copy per link.

  logic [7:0] bank_q [0:1][0:`SLT_BANK_REGS-1];
  logic [4:0] widx;
  logic [4:0] ridx;

  // Bit 4 flags a hit; bits 3:0 index the bank.
  function automatic logic [4:0] bank_index(input logic [11:0] a);
    case (a)
      `SLT_A_DID:     bank_index = 5'h10;
      `SLT_A_BID:     bank_index = 5'h11;
      `SLT_A_LID:     bank_index = 5'h12;
      `SLT_A_LANES:   bank_index = 5'h13;
      `SLT_A_OCTETS:  bank_index = 5'h14;
      `SLT_A_FRAMES:  bank_index = 5'h15;
      `SLT_A_CONVS:   bank_index = 5'h16;
      `SLT_A_RESOL:   bank_index = 5'h17;
      `SLT_A_NPBITS:  bank_index = 5'h18;
      `SLT_A_VERSION: bank_index = 5'h19;
      `SLT_A_DENSITY: bank_index = 5'h1a;
      `SLT_A_CSUM:    bank_index = 5'h1b;
      `SLT_A_LANEEN:  bank_index = 5'h1c;
      `SLT_A_DESKEW:  bank_index = 5'h1d;
      `SLT_A_FSET:    bank_index = 5'h1e;
      default:        bank_index = 5'h00;
    endcase
  endfunction

  assign widx = bank_index(addr_q);
  assign ridx = widx;

  // Deskew and frame-octet settings sit above the thirteen stored words
  // and are held in the spare pair below.
  logic [7:0] deskew_q [0:1];
  logic [7:0] fset_q   [0:1];

  generate
    for (genvar gl = 0; gl < 2; gl++) begin : g_link
      always_ff @(posedge CLOCK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          for (int i = 0; i < `SLT_BANK_REGS; i++) begin
            bank_q[gl][i] <= `SLT_R_ZERO;
          end
          deskew_q[gl] <= `SLT_R_ZERO;
          fset_q[gl]   <= `SLT_R_ZERO;
        end else if (wr_q & widx[4] & (lsel == 1'(gl))) begin
          if (widx[3:0] == 4'hd) begin
            deskew_q[gl] <= wdata_q;
          end else if (widx[3:0] == 4'he) begin
            fset_q[gl] <= wdata_q;
          end else begin
            bank_q[gl][widx[3:0]] <= wdata_q;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero.

  logic [7:0] status;

  assign status = {5'h00, ID_MISMATCH, linkctl_q[`SLT_B_DUAL],
                   LINK_POWER_UP};

  always_comb begin
    rdata = 8'h00;
    case (addr_q)
      `SLT_A_FORMAT:  rdata = format_q;
      `SLT_A_FEATURE: rdata = feature_q;
      `SLT_A_INTERP:  rdata = interp_q;
      `SLT_A_GAIN:    rdata = gain_q;
      `SLT_A_DCOFS:   rdata = dcofs_q;
      `SLT_A_PHASE:   rdata = phase_q;
      `SLT_A_GDELAY:  rdata = gdelay_q;
      `SLT_A_STATUS:  rdata = status;
      `SLT_A_IFPWR:   rdata = ifpwr_q;
      `SLT_A_LANEPD:  rdata = lanepd_q;
      `SLT_A_LINKCTL: rdata = linkctl_q;
      default: begin
        if (ridx[4] & ridx[3:0] == 4'hd) begin
          rdata = deskew_q[lsel];
        end else if (ridx[4] & ridx[3:0] == 4'he) begin
          rdata = fset_q[lsel];
        end else if (ridx[4]) begin
          rdata = bank_q[lsel][ridx[3:0]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Identifier check and published link state.

  logic [7:0] ver0;

  assign ver0 = bank_q[0][9];

  always_ff @(posedge CLOCK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ID_MISMATCH     <= 1'b0;
      LINK_POWER_UP   <= 1'b0;
      LANE_ACTIVE     <= 8'h00;
      DESKEW_LANES    <= 8'h00;
      LANE_COUNT_M1   <= 5'h00;
      PROTOCOL_REV_B  <= 1'b0;
      TWO_LINK_ENABLE <= 1'b0;
    end else begin
      if (RX_ID_VALID) begin
        ID_MISMATCH <= (RX_DID != bank_q[RX_ID_LINK][0]) |
                       (RX_BID != bank_q[RX_ID_LINK][1]) |
                       (RX_LID != bank_q[RX_ID_LINK][2]);
      end
      LINK_POWER_UP   <= ifpwr_q == 8'h00;
      LANE_ACTIVE     <= bank_q[0][12] & ~lanepd_q;
      DESKEW_LANES    <= deskew_q[0];
      LANE_COUNT_M1   <= bank_q[0][3][4:0];
      PROTOCOL_REV_B  <= ver0[7:`SLT_VER_LSB] == `SLT_VER_REV_B;
      TWO_LINK_ENABLE <= linkctl_q[`SLT_B_DUAL];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample path: buffer absorbs a receiver stall, then the datapath.

  slt_dp_cfg_t cfg;
  logic [15:0] bdata;
  logic        bvalid;
  logic        bready;

  always_comb begin
    cfg.unsigned_fmt = format_q[`SLT_B_FMT];
    cfg.mod_en       = feature_q[`SLT_B_MOD];
    cfg.isinc_en     = feature_q[`SLT_B_ISINC];
    cfg.phase_en     = feature_q[`SLT_B_PHASE];
    cfg.dc_en        = feature_q[`SLT_B_DCOFS];
    cfg.prot_en      = feature_q[`SLT_B_PROT];
    cfg.link_up      = LINK_POWER_UP;
    cfg.interp       = interp_q[1:0];
    cfg.gdelay       = gdelay_q[1:0];
    cfg.gain         = gain_q;
    cfg.dc_ofs       = dcofs_q;
    cfg.phase        = phase_q;
  end

  slt_buf2 #(
    .W (16)
  ) u_buf (
    .clk       (CLOCK),
    .rst_n     (rst_n_q),
    .in_data   (SAMPLE_IN),
    .in_valid  (SAMPLE_IN_VALID),
    .in_ready  (SAMPLE_IN_READY),
    .out_data  (bdata),
    .out_valid (bvalid),
    .out_ready (bready)
  );

  slt_datapath u_dp (
    .clk       (CLOCK),
    .rst_n     (rst_n_q),
    .cfg       (cfg),
    .in_data   (bdata),
    .in_valid  (bvalid),
    .in_ready  (bready),
    .out_data  (DAC_DATA),
    .out_valid (DAC_VALID),
    .out_ready (DAC_READY)
  );

endmodule

`default_nettype wire

// [tb/serial_link_transport_config_bench.sv]
/*
 Self-checking bench of the transport configuration bank.
 Assumes the design, checker and transmitter model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module serial_link_transport_config_bench;
  logic        CLOCK, RST_N, SPI_CS_N, SPI_SCLK, SPI_SDI, DAC_READY;
  logic        SPI_SDO, SPI_SDO_OE_N, SAMPLE_IN_VALID, SAMPLE_IN_READY;
  logic        DAC_VALID, RX_ID_VALID, RX_ID_LINK, ID_MISMATCH, stall;
  logic        LINK_POWER_UP, PROTOCOL_REV_B, TWO_LINK_ENABLE;
  logic [15:0] SAMPLE_IN, DAC_DATA, prv;
  logic [7:0]  RX_DID, RX_BID, RX_LID, LANE_ACTIVE, DESKEW_LANES;
  logic [4:0]  LANE_COUNT_M1;
  logic [31:0] lf = 32'hcf942b94;
  logic [15:0] exp_q[$];
  int          error_cnt, n_tests;

  slt_top DUT (.*);
  slt_link_tx tx (.clk(CLOCK), .ready(SAMPLE_IN_READY), .data(SAMPLE_IN),
    .valid(SAMPLE_IN_VALID), .id_valid(RX_ID_VALID), .id_link(RX_ID_LINK),
    .expected_device_identifier(RX_DID), .expected_bank_identifier(RX_BID), .expected_lane_identifier(RX_LID));

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  always @(posedge CLOCK) begin
    #1;
    lf = nxt(lf);
    DAC_READY = !stall && lf[0];
  end

  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Serial clock phases last four cycles, above the two the port needs.
  task automatic spi(input logic rw, input logic [11:0] a,
                     input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    f = {rw, 3'h0, a, wd};
    rd = 8'h00;
    SPI_CS_N = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      SPI_SDI = f[i];
      SPI_SCLK = 1'b0;
      tick(4);
      if (i < 8)
        rd[i] = SPI_SDO;
      SPI_SCLK = 1'b1;
      tick(4);
    end
    SPI_CS_N = 1'b1;
    SPI_SCLK = 1'b0;
    tick(4);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi(1'b0, a, d, r);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] r;
    spi(1'b1, a, 8'h00, r);
    chk(r === e, "register read");
  endtask

  // Modes 0 plain, 1 unsigned, 2 half gain, 3 zero, 4 delayed, 5 offset.
  task automatic burst(input int n, input int rep, input int mode);
    logic [15:0] v;
    logic [15:0] e;
    for (int i = 0; i < n; i++) begin
      v = lf[15:0] & 16'hfffe;
      e = mode == 1 ? v ^ 16'h8000 : mode == 2 ? {v[15], v[15:1]} : v;
      if (mode == 3)
        e = 16'h0000;
      if (mode == 5)
        e = $signed(v) > 16'sh7fef ? 16'h7fff : v + 16'h0010;
      if (mode == 4)
        {e, prv} = {prv, e};
      else
        prv = e;
      repeat (rep) exp_q.push_back(e);
      tx.send(v, lf[5] & lf[9]);
    end
    tx.idle();
  endtask

  task automatic drain;
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++)
      tick(1);
    chk(exp_q.size() == 0, "samples missing");
  endtask

  task automatic idchk(input logic l, input logic [7:0] d,
                       input logic [7:0] b, input logic [7:0] n,
                       input logic e);
    tx.ids(l, d, b, n);
    tick(3);
    chk(ID_MISMATCH === e, "identifier check");
  endtask

  always @(negedge CLOCK) begin
    if (DAC_VALID === 1'b1 && DAC_READY === 1'b1) begin
      if (exp_q.size() == 0)
        chk(1'b0, "sample not expected");
      else
        chk(DAC_DATA === exp_q.pop_front(), "sample value");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    RST_N = 1'b0;
    SPI_CS_N = 1'b1;
    SPI_SCLK = 1'b0;
    SPI_SDI = 1'b0;
    DAC_READY = 1'b0;
    stall = 1'b0;
    tick(2);
    RST_N = 1'b1;
    tick(4);
    rdchk(12'h110, 8'h00);
    rdchk(12'h111, 8'h02);
    rdchk(12'h113, 8'h40);
    rdchk(12'h116, 8'h00);
    rdchk(12'h200, 8'hff);
    wr(12'h123, 8'h5a);
    rdchk(12'h123, 8'h00);
    wr(12'h111, 8'h00);
    burst(6, 1, 0);
    drain();
    wr(12'h110, 8'h80);
    burst(6, 1, 1);
    drain();
    wr(12'h110, 8'h00);
    wr(12'h113, 8'h20);
    burst(6, 1, 2);
    drain();
    wr(12'h113, 8'h40);
    wr(12'h114, 8'h01);
    wr(12'h111, 8'h08);
    burst(4, 1, 5);
    drain();
    wr(12'h111, 8'h10);
    burst(4, 1, 3);
    drain();
    wr(12'h111, 8'h00);
    wr(12'h116, 8'h01);
    burst(4, 1, 4);
    drain();
    wr(12'h116, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(12'h112, 8'(m));
      burst(3, 1 << m, 0);
      drain();
    end
    wr(12'h112, 8'h00);
    stall = 1'b1;
    fork
      burst(6, 1, 0);
      begin
        tick(30);
        chk(SAMPLE_IN_READY === 1'b0, "buffer never full");
        stall = 1'b0;
      end
    join
    drain();
    chk(LINK_POWER_UP === 1'b0, "powered early");
    wr(12'h200, 8'h00);
    chk(LINK_POWER_UP === 1'b1, "not powered");
    wr(12'h453, 8'h87);
    chk(LANE_COUNT_M1 === 5'h07, "lane count");
    wr(12'h459, 8'h20);
    chk(PROTOCOL_REV_B === 1'b1, "revision b");
    wr(12'h459, 8'h00);
    chk(PROTOCOL_REV_B === 1'b0, "revision a");
    wr(12'h457, 8'h0f);
    wr(12'h458, 8'h0f);
    wr(12'h45a, 8'h00);
    wr(12'h47d, 8'hff);
    wr(12'h46c, 8'h3c);
    for (int k = 0; k < 3; k++)
      wr(12'h450 + 12'(k), 8'(8'h11 * (k + 1)));
    wr(12'h300, 8'h0c);
    chk(TWO_LINK_ENABLE === 1'b1, "dual link");
    wr(12'h453, 8'h03);
    for (int k = 0; k < 3; k++)
      wr(12'h450 + 12'(k), 8'(8'h11 * (k + 4)));
    wr(12'h201, 8'h0f);
    chk(LANE_COUNT_M1 === 5'h07, "bank leak");
    rdchk(12'h453, 8'h03);
    wr(12'h300, 8'h08);
    rdchk(12'h453, 8'h87);
    rdchk(12'h201, 8'h0f);
    chk(LANE_ACTIVE === 8'hf0, "active lanes");
    chk(DESKEW_LANES === 8'h3c, "deskew lanes");
    idchk(1'b0, 8'h11, 8'h22, 8'h33, 1'b0);
    idchk(1'b1, 8'h11, 8'h22, 8'h33, 1'b1);
    idchk(1'b1, 8'h44, 8'h55, 8'h66, 1'b0);
    idchk(1'b0, 8'h11, 8'h22, 8'h34, 1'b1);
    report_and_stop();
  end

  // Forty-four frames of about two hundred cycles plus the samples.
  initial begin
    #1000000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire

// [tb/slt_link_tx.sv]
/*
 Link transmitter model: sends samples and identifiers.
 Assumes its tasks are entered just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none

module slt_link_tx (
  input  wire logic        clk,
  input  wire logic        ready,
  output var  logic [15:0] data,
  output var  logic        valid,
  output var  logic        id_valid,
  output var  logic        id_link,
  output var  logic [7:0]  expected_device_identifier,
  output var  logic [7:0]  expected_bank_identifier,
  output var  logic [7:0]  expected_lane_identifier
);
  initial begin
    data = 16'h0000;
    valid = 1'b0;
    id_valid = 1'b0;
    id_link = 1'b0;
    expected_device_identifier = 8'h00;
    expected_bank_identifier = 8'h00;
    expected_lane_identifier = 8'h00;
  end

  // A released word shows its inverse, so a stale word never looks valid.
  task automatic idle;
    valid = 1'b0;
    data = ~data;
  endtask

  task automatic send(input logic [15:0] v, input logic gap);
    if (gap) begin
      idle();
      @(posedge clk);
      #1;
    end
    data = v;
    valid = 1'b1;
    do
      @(posedge clk);
    while (ready !== 1'b1);
    #1;
  endtask

  task automatic ids(input logic l, input logic [7:0] d,
                     input logic [7:0] b, input logic [7:0] n);
    id_link = l;
    expected_device_identifier = d;
    expected_bank_identifier = b;
    expected_lane_identifier = n;
    id_valid = 1'b1;
    @(posedge clk);
    #1;
    id_valid = 1'b0;
    expected_device_identifier = ~d;
    expected_bank_identifier = ~b;
    expected_lane_identifier = ~n;
  endtask
endmodule
`default_nettype wire

// [tb/slt_top_asserts.sv]
/*
 Pin checks of the transport configuration bank.
 Assumes binding to slt_top; one clock, active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module slt_top_asserts (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        SPI_CS_N,
  input wire logic        SPI_SDO_OE_N,
  input wire logic [15:0] DAC_DATA,
  input wire logic        DAC_VALID,
  input wire logic        DAC_READY,
  input wire logic        RX_ID_VALID,
  input wire logic        ID_MISMATCH,
  input wire logic        LINK_POWER_UP,
  input wire logic [7:0]  LANE_ACTIVE,
  input wire logic [4:0]  LANE_COUNT_M1,
  input wire logic        PROTOCOL_REV_B,
  input wire logic        TWO_LINK_ENABLE
);
  // Cycles since select was low; settings may only move during a frame or just after it.
  logic [3:0] idle_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      idle_q <= 4'hf;
    end else if (!SPI_CS_N) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hf) begin
      idle_q <= idle_q + 4'h1;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////
  a_power_by_frame: assert property (
    $changed(LINK_POWER_UP) |-> idle_q < 4'h8)
    else $error("link power moved without a frame");
  a_lanes_by_frame: assert property (
    $changed(LANE_COUNT_M1) |-> idle_q < 4'h8)
    else $error("lane count moved without a frame");
  a_rev_by_frame: assert property (
    $changed(PROTOCOL_REV_B) |-> idle_q < 4'h8)
    else $error("version moved without a frame");
  a_dual_by_frame: assert property (
    $changed(TWO_LINK_ENABLE) |-> idle_q < 4'h8)
    else $error("dual link moved without a frame");
  a_active_by_frame: assert property (
    $changed(LANE_ACTIVE) |-> idle_q < 4'h8)
    else $error("active lanes moved without a frame");
  a_id_on_pulse: assert property (
    $changed(ID_MISMATCH) |-> $past(RX_ID_VALID) || $past(RX_ID_VALID, 2))
    else $error("mismatch moved without identifiers");
  a_sample_held: assert property (
    DAC_VALID && !DAC_READY |=> DAC_VALID && $stable(DAC_DATA))
    else $error("sample dropped during stall");
  a_sdo_released: assert property (
    SPI_CS_N [*4] |-> SPI_SDO_OE_N)
    else $error("read data driven while deselected");
endmodule

bind slt_top slt_top_asserts u_asserts (
  .CLOCK, .RST_N, .SPI_CS_N, .SPI_SDO_OE_N, .DAC_DATA, .DAC_VALID,
  .DAC_READY, .RX_ID_VALID, .ID_MISMATCH, .LINK_POWER_UP, .LANE_ACTIVE,
  .LANE_COUNT_M1, .PROTOCOL_REV_B, .TWO_LINK_ENABLE
);
`default_nettype wire
